// ===== rtl/scr_pkg.sv
/*
 Constants, field layout and carrier types of the system configuration
 register bank. Assumes a single clock domain and an APB register bus.
*/
package scr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] SCR_SYS_ADDR  = 32'h01c00000;
  localparam logic [31:0] SCR_WIN0_ADDR = 32'h01c00004;
  localparam logic [31:0] SCR_WIN1_ADDR = 32'h01c00008;
  localparam logic [31:0] SCR_PRIO_ADDR = 32'h01c40000;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  SCR_SYS_RST   = 8'h01;
  localparam logic [31:0] SCR_WIN_RST   = 32'h00000000;
  localparam logic [31:0] SCR_PRIO_RST  = 32'h80001b1b;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SCR_ABORT_BIT  = 5;
  localparam int SCR_RDWAIT_BIT = 4;
  localparam int SCR_WBUF_BIT   = 3;
  localparam int SCR_CM_LSB     = 1;
  localparam int SCR_BRWAIT_BIT = 0;
  localparam int SCR_FIX_BIT    = 31;
  localparam int SCR_VIEW_LSB   = 8;
  localparam int SCR_END_LSB    = 16;
  localparam int SCR_BLK_LSB    = 12;
  localparam logic [1:0] SCR_RANK_LAST = 2'h3;

  // Cache modes
  localparam logic [1:0] SCR_CM_NONE = 2'h0;
  localparam logic [1:0] SCR_CM_HALF = 2'h1;
  localparam logic [1:0] SCR_CM_RSVD = 2'h2;
  localparam logic [1:0] SCR_CM_FULL = 2'h3;

  // Configuration levels towards cache, buffer and core
  typedef struct packed {
    logic       abort_suppress;
    logic       read_wait_option;
    logic       write_buf_en;
    logic [1:0] cache_config;
    logic       branch_wait_option;
  } scr_cfg_t;

  // Ranks, display DMA at the top as in the register
  typedef struct packed {
    logic [1:0] display_dma;
    logic [1:0] general_dma;
    logic [1:0] bridge_dma;
    logic [1:0] ext_master;
  } scr_rank_t;

endpackage : scr_pkg

// ===== rtl/scr_regs.sv
/*
 System configuration register bank: cache, write buffer and stall
 options, two uncached windows and bus master ranking. Assumes an APB
 master on clk and same-clock request inputs from cache and arbiter.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
module scr_regs #(
  parameter int ADDR_W = 32
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata_ff,
  output logic                   pready_ff,
  output logic                   pslverr_ff,
  input  wire logic              core_rd_req,
  input  wire logic              core_nonseq_req,
  input  wire logic              lookup_valid,
  input  wire logic [31:0]       lookup_addr,
  input  wire logic [3:0]        served,
  output scr_pkg::scr_cfg_t      cfg_ff,
  output logic                   wait_ff,
  output logic                   fill_inhibit_ff,
  output logic                   prio_fixed_ff,
  output scr_pkg::scr_rank_t     rank_ff
);

  // ****************************************
  // Helpers
  // ****************************************
  // Block lies inside a window: start <= blk < end
  function automatic logic in_win(input logic [31:0] win,
                                  input logic [19:0] blk);
    logic [19:0] st;
    logic [19:0] en;
    st = {4'h0, win[scr_pkg::SCR_END_LSB-1:0]};
    en = {4'h0, win[31:scr_pkg::SCR_END_LSB]};
    in_win = (blk >= st) && (blk < en);
  endfunction : in_win

  // Served master moves last, those below it move up
  function automatic logic [7:0] rr_next(input logic [7:0] rk,
                                         input logic [3:0] srv);
    logic [7:0] r;
    logic [1:0] s;
    r = rk;
    s = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (srv[i]) begin
        s = rk[2*i +: 2];
      end
    end
    if (|srv) begin
      for (int i = 0; i < 4; i++) begin
        if (srv[i]) begin
          r[2*i +: 2] = scr_pkg::SCR_RANK_LAST;
        end else if (rk[2*i +: 2] > s) begin
          r[2*i +: 2] = rk[2*i +: 2] - 2'h1;
        end
      end
    end
    rr_next = r;
  endfunction : rr_next

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]         sys_ff;
  logic [7:0]         nxt_sys;
  logic [31:0]        win0_ff;
  logic [31:0]        nxt_win0;
  logic [31:0]        win1_ff;
  logic [31:0]        nxt_win1;
  logic               nxt_fixed;
  logic [7:0]         prio_wr_ff;
  logic [7:0]         nxt_prio_wr;
  scr_pkg::scr_rank_t nxt_rank;
  logic [31:0]        nxt_prdata;
  logic               nxt_pready;
  logic               nxt_pslverr;
  logic               wr_en;
  logic               sel_sys;
  logic               sel_w0;
  logic               sel_w1;
  logic               sel_pr;
  logic               mapped;
  logic [31:0]        rd_mux;

  // Address decode of the four words
  always_comb begin
    sel_sys = (32'(paddr) == scr_pkg::SCR_SYS_ADDR);
    sel_w0  = (32'(paddr) == scr_pkg::SCR_WIN0_ADDR);
    sel_w1  = (32'(paddr) == scr_pkg::SCR_WIN1_ADDR);
    sel_pr  = (32'(paddr) == scr_pkg::SCR_PRIO_ADDR);
    mapped  = sel_sys | sel_w0 | sel_w1 | sel_pr;
    wr_en   = psel & penable & pready_ff & pwrite;
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_sys) begin
      rd_mux = {24'h000000, 2'h0, sys_ff[5:0]};
    end else if (sel_w0) begin
      rd_mux = win0_ff;
    end else if (sel_w1) begin
      rd_mux = win1_ff;
    end else if (sel_pr) begin
      rd_mux = {prio_fixed_ff, 15'h0000, rank_ff, prio_wr_ff};
    end
  end

  // ****************************************
  // APB slave: one wait cycle, then ready
  // ****************************************
  always_comb begin
    nxt_pready  = psel & penable & ~pready_ff;
    nxt_pslverr = psel & penable & ~pready_ff & ~mapped;
    nxt_prdata  = prdata_ff;
    if (psel & penable & ~pready_ff & ~pwrite) begin
      nxt_prdata = rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  always_comb begin
    nxt_sys     = sys_ff;
    nxt_win0    = win0_ff;
    nxt_win1    = win1_ff;
    nxt_fixed   = prio_fixed_ff;
    nxt_prio_wr = prio_wr_ff;
    if (wr_en && sel_sys) begin
      nxt_sys = {2'h0, pwdata[5:0]};
    end
    if (wr_en && sel_w0) begin
      nxt_win0 = pwdata;
    end
    if (wr_en && sel_w1) begin
      nxt_win1 = pwdata;
    end
    if (wr_en && sel_pr) begin
      nxt_fixed   = pwdata[scr_pkg::SCR_FIX_BIT];
      nxt_prio_wr = pwdata[7:0];
    end
  end

  // Ranks in force: written ranks when fixed, rotation otherwise
  always_comb begin
    if (prio_fixed_ff) begin
      nxt_rank = scr_pkg::scr_rank_t'(prio_wr_ff);
    end else begin
      nxt_rank = scr_pkg::scr_rank_t'(rr_next(rank_ff, served));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_ff        <= scr_pkg::SCR_SYS_RST;
      win0_ff       <= scr_pkg::SCR_WIN_RST;
      win1_ff       <= scr_pkg::SCR_WIN_RST;
      prio_fixed_ff <= scr_pkg::SCR_PRIO_RST[scr_pkg::SCR_FIX_BIT];
      prio_wr_ff    <= scr_pkg::SCR_PRIO_RST[7:0];
      rank_ff       <= scr_pkg::SCR_PRIO_RST[15:8];
    end else begin
      sys_ff        <= nxt_sys;
      win0_ff       <= nxt_win0;
      win1_ff       <= nxt_win1;
      prio_fixed_ff <= nxt_fixed;
      prio_wr_ff    <= nxt_prio_wr;
      rank_ff       <= nxt_rank; // wrapper sits below the other three
    end
  end

  // ****************************************
  // Configuration levels and stall/fill control
  // ****************************************
  scr_pkg::scr_cfg_t nxt_cfg;
  logic              nxt_wait;
  logic              nxt_inhibit;
  logic [19:0]       lk_blk;

  always_comb begin
    nxt_cfg.abort_suppress     = nxt_sys[scr_pkg::SCR_ABORT_BIT];
    nxt_cfg.read_wait_option   = nxt_sys[scr_pkg::SCR_RDWAIT_BIT];
    nxt_cfg.write_buf_en       = nxt_sys[scr_pkg::SCR_WBUF_BIT];
    nxt_cfg.cache_config       = nxt_sys[scr_pkg::SCR_CM_LSB +: 2];
    nxt_cfg.branch_wait_option = nxt_sys[scr_pkg::SCR_BRWAIT_BIT];
    // One wait for a read, or a non-sequential caching fetch
    nxt_wait = (core_rd_req & cfg_ff.read_wait_option)
             | (core_nonseq_req & cfg_ff.branch_wait_option
                & (cfg_ff.cache_config != scr_pkg::SCR_CM_NONE));
    lk_blk      = lookup_addr[31:scr_pkg::SCR_BLK_LSB];
    nxt_inhibit = lookup_valid
                & (in_win(win0_ff, lk_blk) | in_win(win1_ff, lk_blk));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_ff          <= scr_pkg::scr_cfg_t'(scr_pkg::SCR_SYS_RST[5:0]);
      wait_ff         <= 1'b0;
      fill_inhibit_ff <= 1'b0;
    end else begin
      cfg_ff          <= nxt_cfg;
      wait_ff         <= nxt_wait;
      fill_inhibit_ff <= nxt_inhibit;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_abort_write: assert property (wr_en && sel_sys |=>
    cfg_ff.abort_suppress == $past(pwdata[5]))
    else $error("abort suppress not updated");
  chk_read_wait: assert property (core_rd_req && cfg_ff.read_wait_option
    |=> wait_ff) else $error("read wait missing");
  chk_no_wait: assert property (!core_rd_req && !core_nonseq_req
    |=> !wait_ff) else $error("spurious wait");
  chk_wbuf_write: assert property (wr_en && sel_sys |=>
    cfg_ff.write_buf_en == $past(pwdata[3])) else $error("wbuf bit wrong");
  chk_cache_mode: assert property (wr_en && sel_sys |=>
    cfg_ff.cache_config == $past(pwdata[2:1])) else $error("cache mode wrong");
  chk_branch_wait: assert property (core_nonseq_req &&
    cfg_ff.branch_wait_option && cfg_ff.cache_config == 2'h3 |=> wait_ff)
    else $error("branch wait missing");
  chk_win_inhibit: assert property (lookup_valid &&
    lookup_addr[31:12] >= {4'h0, win0_ff[15:0]} &&
    lookup_addr[31:12] < {4'h0, win0_ff[31:16]} && $stable(win0_ff)
    |=> fill_inhibit_ff) else $error("window fill not inhibited");
  chk_fixed_view: assert property (prio_fixed_ff ##1 $stable(prio_wr_ff)
    |-> rank_ff == prio_wr_ff)
    else $error("fixed ranks not in force");
  chk_rr_last: assert property (!prio_fixed_ff && served == 4'h8
    |=> rank_ff.display_dma == 2'h3) else $error("served not last");
  chk_apb_ready: assert property (psel && penable && !pready_ff
    |=> pready_ff ##1 !pready_ff) else $error("ready timing");
  // Unmapped word answers with an error
  chk_bad_addr: assert property (psel && penable && !pready_ff && !mapped
    |=> pslverr_ff && pready_ff) else $error("unmapped word not refused");
  // Second window, checked on its own
  chk_win1_inhibit: assert property (lookup_valid &&
    lookup_addr[31:12] >= {4'h0, win1_ff[15:0]} &&
    lookup_addr[31:12] < {4'h0, win1_ff[31:16]}
    |=> fill_inhibit_ff) else $error("window 1 fill not inhibited");
  // Nothing to classify, nothing to inhibit
  chk_no_lookup: assert property (!lookup_valid |=> !fill_inhibit_ff)
    else $error("inhibit without lookup");
  // Addresses outside both windows stay cacheable
  chk_win_outside: assert property (lookup_valid &&
    (lookup_addr[31:12] < {4'h0, win0_ff[15:0]} ||
     lookup_addr[31:12] >= {4'h0, win0_ff[31:16]}) &&
    (lookup_addr[31:12] < {4'h0, win1_ff[15:0]} ||
     lookup_addr[31:12] >= {4'h0, win1_ff[31:16]})
    |=> !fill_inhibit_ff) else $error("cacheable address inhibited");
  // Priority word write lands in mode and written ranks
  chk_prio_write: assert property (wr_en && sel_pr |=>
    prio_fixed_ff == $past(pwdata[31]) && prio_wr_ff == $past(pwdata[7:0]))
    else $error("priority word not written");
  // Read of the priority word shows the ranks in force
  chk_view_read: assert property (psel && penable && !pready_ff && !pwrite && sel_pr
    |=> prdata_ff[15:8] == $past(rank_ff)) else $error("rank view wrong");
  // Reserved system bits read as zero
  chk_sys_read: assert property (psel && penable && !pready_ff && !pwrite && sel_sys
    |=> prdata_ff[31:6] == 26'h0000000) else $error("reserved system bits set");
  // A refused write leaves the system and window registers alone
  chk_write_ignored: assert property (wr_en && !mapped |=> $stable(sys_ff) &&
    $stable(win0_ff) && $stable(win1_ff)) else $error("refused write landed");
  // Round-robin without service keeps the order
  chk_rr_hold: assert property (!prio_fixed_ff && served == 4'h0
    |=> $stable(rank_ff)) else $error("ranks moved without service");
  // No branch wait while the option is off
  chk_branch_off: assert property (core_nonseq_req && !core_rd_req
    && !cfg_ff.branch_wait_option |=> !wait_ff) else $error("spurious branch wait");

  cov_rr_turn: cover property (!prio_fixed_ff && served == 4'h1);
  cov_win_hit: cover property (fill_inhibit_ff);
  cov_bad_addr: cover property (pslverr_ff);
  cov_fixed_write: cover property (wr_en && sel_pr && pwdata[31]);
  cov_read_wait: cover property (wait_ff && cfg_ff.read_wait_option);

endmodule : scr_regs

// ===== tb/testbench.sv
/*
 Self-checking bench for the system configuration register bank.
 Assumes scr_pkg and scr_regs are compiled first; the bench is the APB master.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  // ****************************************
  // Signals and design instance
  // ****************************************
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } scr_row_t;
  logic               clk, reset_n, psel, penable, pwrite, pready_ff, pslverr_ff;
  logic [31:0]        paddr, pwdata, prdata_ff, lookup_addr, rd;
  logic               core_rd_req, core_nonseq_req, lookup_valid, wait_ff;
  logic               fill_inhibit_ff, prio_fixed_ff, er;
  logic [3:0]         served;
  scr_pkg::scr_cfg_t  cfg_ff;
  scr_pkg::scr_rank_t rank_ff;
  scr_row_t           rows [10];
  int                 num_errors, total_checks, cycles;
  scr_regs i_scr_regs (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .core_rd_req(core_rd_req),
    .core_nonseq_req(core_nonseq_req), .lookup_valid(lookup_valid),
    .lookup_addr(lookup_addr), .served(served), .cfg_ff(cfg_ff), .wait_ff(wait_ff),
    .fill_inhibit_ff(fill_inhibit_ff), .prio_fixed_ff(prio_fixed_ff), .rank_ff(rank_ff));
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // One APB transfer, entered just after a rising edge
  // Waits for ready however long it takes; only the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // One stall request, answer looked at one cycle later
  task automatic stall(input logic r, input logic s, input logic ex);
    core_rd_req <= r; core_nonseq_req <= s;
    @(posedge clk);
    core_rd_req <= 1'b0; core_nonseq_req <= 1'b0;
    #1 `CHK(wait_ff, ex)
    @(posedge clk);
  endtask : stall
  task automatic look(input logic [31:0] a, input logic ex);
    lookup_valid <= 1'b1; lookup_addr <= a;
    @(posedge clk);
    lookup_valid <= 1'b0;
    #1 `CHK(fill_inhibit_ff, ex)
    @(posedge clk);
  endtask : look
  task automatic serve(input logic [3:0] s, input logic [7:0] ex);
    served <= s;
    @(posedge clk);
    served <= 4'h0;
    #1 `CHK(rank_ff, ex)
    @(posedge clk);
  endtask : serve
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    core_rd_req = 0; core_nonseq_req = 0; lookup_valid = 0; lookup_addr = 0; served = 0;
    num_errors = 0; total_checks = 0; cycles = 0;
    rows = '{'{32'h01c00000, 32'hffffffff, 32'h0000003f, 1'b0},
             '{32'h01c00000, 32'h00000022, 32'h00000022, 1'b0},
             '{32'h01c00000, 32'h0000000c, 32'h0000000c, 1'b0},
             '{32'h01c00000, 32'h00000006, 32'h00000006, 1'b0},
             '{32'h01c00000, 32'h00000000, 32'h00000000, 1'b0},
             '{32'h01c00004, 32'h00230010, 32'h00230010, 1'b0},
             '{32'h01c00008, 32'h00050004, 32'h00050004, 1'b0},
             '{32'h01c40000, 32'h800000e4, 32'h8000e4e4, 1'b0},
             '{32'h01c0000c, 32'h12345678, 32'h00000000, 1'b1},
             '{32'h01c40004, 32'h00000000, 32'h00000000, 1'b1}};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Reset values of outputs and registers
    #1 `CHK(cfg_ff, 6'h01)
    `CHK(rank_ff, 8'h1b)
    `CHK(prio_fixed_ff, 1'b1)
    @(posedge clk);
    apb(1'b0, scr_pkg::SCR_SYS_ADDR, 32'h0); `CHK(rd, 32'h00000001)
    apb(1'b0, scr_pkg::SCR_WIN0_ADDR, 32'h0); `CHK(rd, 32'h00000000)
    apb(1'b0, scr_pkg::SCR_WIN1_ADDR, 32'h0); `CHK(rd, 32'h00000000)
    apb(1'b0, scr_pkg::SCR_PRIO_ADDR, 32'h0); `CHK(rd, 32'h80001b1b)
    $display("reset test done");
    // Table of write, readback and error flag
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d); `CHK(er, rows[i].e)
      apb(1'b0, rows[i].a, 32'h0); `CHK(rd, rows[i].q)
      if (rows[i].a == scr_pkg::SCR_SYS_ADDR) `CHK(cfg_ff, rows[i].q[5:0])
    end
    `CHK(rank_ff, 8'he4)
    $display("table test done");
    // Stall waits
    stall(1'b1, 1'b0, 1'b0);
    stall(1'b0, 1'b1, 1'b0);
    apb(1'b1, scr_pkg::SCR_SYS_ADDR, 32'h00000017);
    stall(1'b1, 1'b0, 1'b1);
    stall(1'b0, 1'b1, 1'b1);
    apb(1'b1, scr_pkg::SCR_SYS_ADDR, 32'h00000001);
    stall(1'b0, 1'b1, 1'b0);
    stall(1'b1, 1'b0, 1'b0);
    $display("stall test done");
    // Window edges, both windows
    look(32'h0000ffff, 1'b0); look(32'h00010000, 1'b1);
    look(32'h00022fff, 1'b1); look(32'h00023000, 1'b0);
    look(32'h00004000, 1'b1); look(32'h00005000, 1'b0);
    $display("window test done");
    // Fixed mode ignores service, round-robin moves served master last
    serve(4'b0001, 8'he4);
    apb(1'b1, scr_pkg::SCR_PRIO_ADDR, 32'h0000001b);
    #1 `CHK(prio_fixed_ff, 1'b0)
    `CHK(rank_ff, 8'he4)
    @(posedge clk);
    serve(4'b1000, 8'he4);
    serve(4'b0001, 8'h93);
    apb(1'b0, scr_pkg::SCR_PRIO_ADDR, 32'h0); `CHK(rd, 32'h0000931b)
    serve(4'b0100, 8'h72);
    apb(1'b1, scr_pkg::SCR_PRIO_ADDR, 32'h8000001b);
    @(posedge clk);
    #1 `CHK(rank_ff, 8'h1b)
    $display("priority test done");
    // Mid-run reset after disturbing every register
    @(posedge clk);
    apb(1'b1, scr_pkg::SCR_SYS_ADDR, 32'h0000003f);
    apb(1'b1, scr_pkg::SCR_PRIO_ADDR, 32'h000000e4);
    serve(4'b1000, 8'hc6);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 `CHK(cfg_ff, 6'h01)
    `CHK(rank_ff, 8'h1b)
    `CHK(prio_fixed_ff, 1'b1)
    @(posedge clk);
    apb(1'b0, scr_pkg::SCR_WIN0_ADDR, 32'h0); `CHK(rd, 32'h00000000)
    apb(1'b0, scr_pkg::SCR_PRIO_ADDR, 32'h0); `CHK(rd, 32'h80001b1b)
    $display("reset restore test done");
    tally_and_finish();
  end
endmodule : testbench
